// File: logic/rcw_clk_div.sv
// half-period counting clock divider with active-low hold and bypass
// assumes clk_level is already synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module rcw_clk_div #(
    parameter int RATIO_W = 5
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [RATIO_W-1:0] ratio,
    input wire logic hold_n,
    // clocks
    input wire logic clk_level,
    output logic div_clk,
    output logic period_start
);
    logic prev_level;
    logic [RATIO_W:0] cnt;
    logic [RATIO_W:0] next_cnt;
    logic next_div_clk;
    logic next_period_start;
    logic edge_seen;
    logic bypass;

    initial begin
        if (RATIO_W < 2) begin
            $error("rcw_clk_div: RATIO_W must be at least 2");
        end
    end

    // ratios below two pass the clock straight through
    function automatic logic is_bypass(input logic [RATIO_W-1:0] r);
        return r < RATIO_W'(2);
    endfunction

    always_comb begin
        edge_seen = clk_level ^ prev_level;
        bypass = is_bypass(ratio);
        next_cnt = cnt;
        next_div_clk = div_clk;
        if (bypass) begin
            next_cnt = '0;
            next_div_clk = clk_level;
        end else if (!hold_n) begin
            // held in set state: output parked high
            next_cnt = '0;
            next_div_clk = 1'b1;
        end else if (edge_seen) begin
            if (cnt == {ratio, 1'b0} - (RATIO_W+1)'(1)) begin
                next_cnt = '0;
            end else begin
                next_cnt = cnt + (RATIO_W+1)'(1);
            end
            next_div_clk = next_cnt < {1'b0, ratio};
        end
        next_period_start = next_div_clk & ~div_clk;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_level <= 1'b0;
            cnt <= '0;
            div_clk <= 1'b1;
            period_start <= 1'b0;
        end else begin
            prev_level <= clk_level;
            cnt <= next_cnt;
            div_clk <= next_div_clk;
            period_start <= next_period_start;
        end
    end
endmodule // rcw_clk_div
`default_nettype wire

// File: logic/rcw_params.svh
// register offsets, field positions and reset values of the reference clock
// input and loss-of-signal window configuration block
// assumes inclusion by bare name from the design files
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

// byte offsets on the register bus
`define RCW_OFF_PAD 12'h000
`define RCW_OFF_WIN 12'h004
`define RCW_OFF_STS 12'h008
`define RCW_OFF_EVT 12'h00c
`define RCW_OFF_MASK 12'h010
`define RCW_OFF_CTRL 12'h014

// pad configuration fields
`define RCW_PAD_HOLD_BIT 15
`define RCW_PAD_RATIO_HI 14
`define RCW_PAD_RATIO_LO 10
`define RCW_PAD_INBUF_BIT 3
`define RCW_PAD_MODE_HI 2
`define RCW_PAD_MODE_LO 1
`define RCW_PAD_PAIR_BIT 0
`define RCW_PAD_RESET 16'h8001
`define RCW_PAD_WMASK 16'hffff

// window configuration fields
`define RCW_WIN_THR_HI 11
`define RCW_WIN_THR_LO 8
`define RCW_WIN_FMASK_BIT 5
`define RCW_WIN_RATIO_HI 4
`define RCW_WIN_RATIO_LO 0
`define RCW_WIN_RESET 16'h0000
`define RCW_WIN_WMASK 16'h0f7f

// status, event and control fields
`define RCW_STS_LOS_BIT 0
`define RCW_STS_INVALID_BIT 1
`define RCW_STS_WCNT_HI 31
`define RCW_STS_WCNT_LO 16
`define RCW_EVT_WIN_BIT 0
`define RCW_EVT_LMT_BIT 1
`define RCW_EVT_WIDTH 2
`define RCW_EVT_RESET 2'h0
`define RCW_MASK_RESET 2'h0
`define RCW_CTRL_SRST_BIT 0
`define RCW_CTRL_RESET 1'h0
`define RCW_INVALID_RESET 1'h1

`endif

// File: logic/rcw_pkg.sv
// types shared by the reference clock configuration block
// assumes nothing beyond a SystemVerilog compiler
package rcw_pkg;

    typedef enum logic [1:0] {
        RCW_MODE_DIFF,
        RCW_MODE_SE_POS,
        RCW_MODE_SE_NEG,
        RCW_MODE_DUAL
    } rcw_input_mode_type;

    typedef struct packed {
        logic hold_n;
        logic [4:0] ratio;
        logic trim_term;
        logic lvpecl_term;
        logic lvds_term;
        logic hcsl_term;
        logic cml_term;
        logic pad_bias_enable;
        logic pad_enable;
        rcw_input_mode_type input_mode;
        logic nmos_pair;
    } rcw_pad_cfg_type;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [3:0] count_threshold;
        logic rsvd7;
        logic rsvd6;
        logic fail_mask;
        logic [4:0] window_ratio;
    } rcw_win_cfg_type;

endpackage

// File: logic/rcw_refclk_los_cfg.sv
// reference clock input pad configuration, high-frequency divider and
// loss-of-signal monitor window setup, reached over apb
// assumes ref_p/ref_n are pins far slower than pclk; monitor inputs on pclk
//
// Contract
// - the reference divider divides by 2..31, passes the clock at ratio 0, 1 is reserved.
// - while the active-low hold bit is 0 the divider stays in its set state; it resets to 1.
// - clearing hold halts the divided clock unless the ratio is 0, which keeps it running.
// - the clock is usable only with the pad enabled; full power-down needs all enables at 0. pad_power_down ignores trim_term.
// - the mode field selects differential, positive pin, negative pin or dual single-ended.
// - the pair select bit picks the pmos pair at 0 and nmos pair at 1, resetting to 1.
// - the loss-limit flag is set while the loss counter exceeds the four-bit threshold.
// - with the failure mask at 1 the loss status does not feed reference-invalid.
// - the monitor divider divides by the five-bit ratio, treating 0 and 1 as one.
// - one period of the divided monitored clock is one monitoring window.
// - the loss-limit flag cannot be cleared while its condition still holds.
// - reference-invalid reads 1 when any unmasked monitor disqualifies the clock; resets to 1.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "rcw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module rcw_refclk_los_cfg #(
    parameter int LOS_CNT_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reference pins
    input wire logic ref_p,
    input wire logic ref_n,
    // monitor inputs
    input wire logic [LOS_CNT_W-1:0] los_count,
    input wire logic los_status,
    input wire logic freq_disqualified,
    // pad and clock outputs
    output rcw_pkg::rcw_pad_cfg_type pad_cfg,
    output logic pad_power_down,
    output logic divided_ref0_clock,
    output logic ref_second_clock,
    output logic monitor_div_clock,
    output logic window_start,
    // monitor control and status
    output logic monitor0_soft_reset,
    output logic ref_invalid,
    output logic irq
);
    rcw_pkg::rcw_pad_cfg_type pad;
    rcw_pkg::rcw_pad_cfg_type next_pad;
    rcw_pkg::rcw_win_cfg_type win;
    rcw_pkg::rcw_win_cfg_type next_win;
    logic [`RCW_EVT_WIDTH-1:0] evt;
    logic [`RCW_EVT_WIDTH-1:0] next_evt;
    logic [`RCW_EVT_WIDTH-1:0] mask;
    logic [`RCW_EVT_WIDTH-1:0] next_mask;
    logic next_soft_reset;
    logic next_invalid;
    logic [15:0] wcnt;
    logic [15:0] next_wcnt;
    logic [15:0] win_len;
    logic [15:0] next_win_len;
    logic [31:0] next_prdata;
    logic [1:0] pin_sync;
    logic ref_lvl;
    logic second_lvl;
    logic lmt_cond;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [`RCW_EVT_WIDTH-1:0] evt_set;
    logic [`RCW_EVT_WIDTH-1:0] evt_clr;

    initial begin
        if (LOS_CNT_W < 4 || LOS_CNT_W > 32) begin
            $error("rcw_refclk_los_cfg: LOS_CNT_W must be 4..32");
        end
    end

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `RCW_OFF_PAD || a == `RCW_OFF_WIN || a == `RCW_OFF_STS ||
               a == `RCW_OFF_EVT || a == `RCW_OFF_MASK || a == `RCW_OFF_CTRL;
    endfunction

    // pins are asynchronous to pclk
    rcw_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({ref_n, ref_p}),
        .sync_out(pin_sync)
    );

    // input mode and pad gating
    always_comb begin
        unique case (pad.input_mode)
            rcw_pkg::RCW_MODE_DIFF: ref_lvl = pin_sync[0];
            rcw_pkg::RCW_MODE_SE_POS: ref_lvl = pin_sync[0];
            rcw_pkg::RCW_MODE_SE_NEG: ref_lvl = pin_sync[1];
            rcw_pkg::RCW_MODE_DUAL: ref_lvl = pin_sync[0];
        endcase
        second_lvl = (pad.input_mode == rcw_pkg::RCW_MODE_DUAL) & pin_sync[1];
        // a disabled pad delivers no clock at all
        ref_lvl = ref_lvl & pad.pad_enable;
        second_lvl = second_lvl & pad.pad_enable;
    end

    // limitation: pins are sampled at pclk, so only slow reference clocks divide exactly
    rcw_clk_div #(
        .RATIO_W(5)
    ) u_ref_div (
        .pclk(pclk),
        .presetn(presetn),
        .ratio(pad.ratio),
        .hold_n(pad.hold_n),
        .clk_level(ref_lvl),
        .div_clk(divided_ref0_clock),
        .period_start()
    );

    // monitor divider; held idle while the monitor is in soft reset, except at window ratio 0 or 1, where it keeps running
    rcw_clk_div #(
        .RATIO_W(5)
    ) u_mon_div (
        .pclk(pclk),
        .presetn(presetn),
        .ratio(win.window_ratio),
        .hold_n(~monitor0_soft_reset),
        .clk_level(ref_lvl),
        .div_clk(monitor_div_clock),
        .period_start(window_start)
    );

    // apb decode: zero wait states, read data captured in the setup cycle
    always_comb begin
        setup = psel & ~penable;
        wr_en = psel & penable & pwrite & is_mapped(paddr);
        mapped = is_mapped(paddr);
        pready = 1'b1;
        pslverr = psel & penable & ~mapped;
        lmt_cond = los_count > LOS_CNT_W'(win.count_threshold);
        evt_set = '0;
        evt_set[`RCW_EVT_LMT_BIT] = lmt_cond;
        evt_set[`RCW_EVT_WIN_BIT] = window_start;
        evt_clr = '0;
        if (wr_en && paddr == `RCW_OFF_EVT) begin
            evt_clr = pwdata[`RCW_EVT_WIDTH-1:0];
        end
        // set beats clear, so a held limit condition cannot be cleared
        next_evt = (evt & ~evt_clr) | evt_set;
        next_pad = pad;
        next_win = win;
        next_mask = mask;
        next_soft_reset = monitor0_soft_reset;
        if (wr_en && paddr == `RCW_OFF_PAD) begin
            next_pad = pwdata[15:0] & `RCW_PAD_WMASK;
        end
        if (wr_en && paddr == `RCW_OFF_WIN) begin
            next_win = pwdata[15:0] & `RCW_WIN_WMASK;
        end
        if (wr_en && paddr == `RCW_OFF_MASK) begin
            next_mask = pwdata[`RCW_EVT_WIDTH-1:0];
        end
        if (wr_en && paddr == `RCW_OFF_CTRL) begin
            next_soft_reset = pwdata[`RCW_CTRL_SRST_BIT];
        end
        next_invalid = (los_status & ~win.fail_mask) | freq_disqualified;
    end

    // window length measured in pclk cycles, saturating
    always_comb begin
        next_wcnt = wcnt;
        next_win_len = win_len;
        if (monitor0_soft_reset) begin
            next_wcnt = '0;
        end else if (window_start) begin
            next_win_len = wcnt;
            next_wcnt = 16'h0001;
        end else if (wcnt != 16'hffff) begin
            next_wcnt = wcnt + 16'h0001;
        end
    end

    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = '0;
            unique case (paddr)
                `RCW_OFF_PAD: next_prdata[15:0] = pad;
                `RCW_OFF_WIN: next_prdata[15:0] = win;
                `RCW_OFF_STS: begin
                    next_prdata[`RCW_STS_LOS_BIT] = los_status;
                    next_prdata[`RCW_STS_INVALID_BIT] = ref_invalid;
                    next_prdata[`RCW_STS_WCNT_HI:`RCW_STS_WCNT_LO] = win_len;
                end
                `RCW_OFF_EVT: next_prdata[`RCW_EVT_WIDTH-1:0] = evt;
                `RCW_OFF_MASK: next_prdata[`RCW_EVT_WIDTH-1:0] = mask;
                `RCW_OFF_CTRL: next_prdata[`RCW_CTRL_SRST_BIT] = monitor0_soft_reset;
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad <= `RCW_PAD_RESET;
            win <= `RCW_WIN_RESET;
            evt <= `RCW_EVT_RESET;
            mask <= `RCW_MASK_RESET;
            monitor0_soft_reset <= `RCW_CTRL_RESET;
            ref_invalid <= `RCW_INVALID_RESET;
            wcnt <= '0;
            win_len <= '0;
            prdata <= '0;
            irq <= 1'b0;
        end else begin
            pad <= next_pad;
            win <= next_win;
            evt <= next_evt;
            mask <= next_mask;
            monitor0_soft_reset <= next_soft_reset;
            ref_invalid <= next_invalid;
            wcnt <= next_wcnt;
            win_len <= next_win_len;
            prdata <= next_prdata;
            irq <= |(next_evt & next_mask);
        end
    end

    // pad fields go straight out; the pair select bit steers the analog input stage
    always_comb begin
        pad_cfg = pad;
        ref_second_clock = second_lvl;
        pad_power_down = ~(pad.pad_enable | pad.pad_bias_enable | pad.cml_term |
                           pad.hcsl_term | pad.lvds_term | pad.lvpecl_term);
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_bypass_follows_clk: assert property (
        ($past(presetn) && pad.ratio == 5'h00) |=> divided_ref0_clock == $past(ref_lvl)
    ) else $error("bypassed divider does not follow the reference");

    a_hold_parks_high: assert property (
        (!pad.hold_n && pad.ratio >= 5'h02)[*2] |-> divided_ref0_clock
    ) else $error("held divider left its set state");

    a_hold_halts_div: assert property (
        (!pad.hold_n && pad.ratio >= 5'h02)[*3] |-> $stable(divided_ref0_clock)
    ) else $error("held divider still toggles");

    a_pad_gates_clk: assert property (
        !pad.pad_enable |-> !ref_lvl && !ref_second_clock
    ) else $error("clock passes a disabled pad");

    a_mode_neg_pin: assert property (
        (pad.input_mode == rcw_pkg::RCW_MODE_SE_NEG && pad.pad_enable) |->
            ref_lvl == pin_sync[1] && !ref_second_clock
    ) else $error("negative pin mode selects the wrong pin");

    a_pair_out: assert property (
        $past(wr_en && paddr == `RCW_OFF_PAD) |-> pad_cfg.nmos_pair == $past(pwdata[0])
    ) else $error("pair select not taken from the write");

    a_limit_flag_set: assert property (
        lmt_cond |=> evt[`RCW_EVT_LMT_BIT]
    ) else $error("loss-limit flag not set over threshold");

    a_limit_no_clear: assert property (
        (lmt_cond && wr_en && paddr == `RCW_OFF_EVT && pwdata[1]) |=> evt[`RCW_EVT_LMT_BIT]
    ) else $error("loss-limit flag cleared while condition holds");

    a_mask_hides_los: assert property (
        (win.fail_mask && !freq_disqualified) |=> !ref_invalid
    ) else $error("masked loss status reached reference-invalid");

    a_invalid_on_los: assert property (
        ((los_status && !win.fail_mask) || freq_disqualified) |=> ref_invalid
    ) else $error("disqualified clock not flagged invalid");

    a_mon_ratio_one: assert property (
        ($past(presetn) && win.window_ratio < 5'h02) |=> monitor_div_clock == $past(ref_lvl)
    ) else $error("monitor ratio 0 or 1 does not divide by one");

    a_window_pulse: assert property (
        window_start |-> monitor_div_clock ##1 !window_start
    ) else $error("window start is not a single rising-edge pulse");

endmodule // rcw_refclk_los_cfg
`default_nettype wire

// File: logic/rcw_sync.sv
// two-flop synchroniser for pin-level inputs
// assumes inputs are quasi-static or slow against pclk
`timescale 1ns/10ps
`default_nettype none
module rcw_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) begin
            $error("rcw_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // rcw_sync
`default_nettype wire

// File: tb/rcw_refclk_los_cfg_bench.sv
// self-checking bench for the reference clock pad and loss window block
// assumes the design files and rcw_params.svh are compiled first
`include "rcw_params.svh"
`timescale 1ns/10ps
`default_nettype none
module rcw_refclk_los_cfg_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic ref_p = 1'b0, ref_n = 1'b0, en_p = 1'b0, en_n = 1'b0;
    logic [7:0] los_count = 8'h00;
    logic los_status = 1'b0, freq_disqualified = 1'b0;
    rcw_pkg::rcw_pad_cfg_type pad_cfg;
    logic pad_power_down, divided_ref0_clock, ref_second_clock;
    logic monitor_div_clock, window_start, monitor0_soft_reset, ref_invalid, irq;
    logic [1:0] tick = 2'h0;
    logic [3:0] probes;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int compares = 0;
    int cyc;

    always #12.5 pclk = ~pclk;
    assign probes = {ref_second_clock, window_start, monitor_div_clock, divided_ref0_clock};

    // pins toggle every 4 cycles: a period of 8 cycles, well inside sampling limits
    always @(posedge pclk) begin
        tick <= tick + 2'h1;
        if (tick == 2'h3) begin
            if (en_p) ref_p <= ~ref_p;
            if (en_n) ref_n <= ~ref_n;
        end
    end

    rcw_refclk_los_cfg rcw_refclk_los_cfg_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_p(ref_p), .ref_n(ref_n),
        .los_count(los_count), .los_status(los_status),
        .freq_disqualified(freq_disqualified), .pad_cfg(pad_cfg),
        .pad_power_down(pad_power_down), .divided_ref0_clock(divided_ref0_clock),
        .ref_second_clock(ref_second_clock), .monitor_div_clock(monitor_div_clock),
        .window_start(window_start), .monitor0_soft_reset(monitor0_soft_reset),
        .ref_invalid(ref_invalid), .irq(irq)
    );

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            bad_count++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one more edge so that outputs launched by the write have settled
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    // cycles between the second and third rising edge of a probe, 0 if none
    task automatic period(input int idx, output int c);
        int n, rises, start;
        logic prev;
        c = 0;
        rises = 0;
        start = 0;
        repeat (64) @(negedge pclk);
        prev = probes[idx];
        for (n = 0; n < 1000 && c == 0; n++) begin
            @(negedge pclk);
            if (!prev && probes[idx]) begin
                rises++;
                if (rises == 2) start = n;
                if (rises == 3) c = n - start;
            end
            prev = probes[idx];
        end
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end

    initial begin
        int r;
        int rl[4];
        repeat (16) @(posedge pclk);
        chk({16'h0, pad_cfg}, 32'h8001);
        chk({31'h0, ref_invalid}, 32'h1);
        presetn <= 1'b1;
        rd_chk(`RCW_OFF_PAD, 32'h8001, 32'hffffffff);
        rd_chk(`RCW_OFF_WIN, 32'h0, 32'hffffffff);
        done("reset");

        apb(1'b1, `RCW_OFF_PAD, 32'h7ffe);
        rd_chk(`RCW_OFF_PAD, 32'h7ffe, 32'hffffffff);
        chk({16'h0, pad_cfg}, 32'h7ffe);
        apb(1'b1, `RCW_OFF_PAD, 32'h0200);
        chk({31'h0, pad_power_down}, 32'h1);
        for (r = 3; r < 9; r++) begin
            apb(1'b1, `RCW_OFF_PAD, 32'h1 << r);
            chk({31'h0, pad_power_down}, 32'h0);
        end
        done("pad");

        apb(1'b1, `RCW_OFF_WIN, 32'hffff);
        rd_chk(`RCW_OFF_WIN, 32'h0f7f, 32'hffffffff);
        apb(1'b0, 12'h018, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        done("window");

        apb(1'b1, `RCW_OFF_WIN, 32'h0500);
        los_count <= 8'h05;
        apb(1'b1, `RCW_OFF_EVT, 32'h3);
        rd_chk(`RCW_OFF_EVT, 32'h0, 32'h2);
        los_count <= 8'h06;
        apb(1'b1, `RCW_OFF_MASK, 32'h2);
        rd_chk(`RCW_OFF_EVT, 32'h2, 32'h2);
        apb(1'b1, `RCW_OFF_EVT, 32'h2);
        rd_chk(`RCW_OFF_EVT, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `RCW_OFF_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        los_count <= 8'h00;
        apb(1'b1, `RCW_OFF_EVT, 32'h2);
        rd_chk(`RCW_OFF_EVT, 32'h0, 32'h2);
        done("loss_limit");

        los_status <= 1'b1;
        apb(1'b1, `RCW_OFF_WIN, 32'h0000);
        rd_chk(`RCW_OFF_STS, 32'h3, 32'h3);
        apb(1'b1, `RCW_OFF_WIN, 32'h0020);
        rd_chk(`RCW_OFF_STS, 32'h1, 32'h3);
        chk({31'h0, ref_invalid}, 32'h0);
        freq_disqualified <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, ref_invalid}, 32'h1);
        freq_disqualified <= 1'b0;
        los_status <= 1'b0;
        done("invalid");

        en_p <= 1'b1;
        rl = '{0, 2, 3, 31};
        foreach (rl[i]) begin
            apb(1'b1, `RCW_OFF_PAD, 32'h800a | (rl[i] << 10));
            period(0, cyc);
            chk(cyc, (rl[i] == 0) ? 8 : 8 * rl[i]);
        end
        apb(1'b1, `RCW_OFF_PAD, 32'h8008);
        period(0, cyc);
        chk(cyc, 8);
        apb(1'b1, `RCW_OFF_PAD, 32'h0c0a);
        period(0, cyc);
        chk(cyc, 0);
        chk({31'h0, divided_ref0_clock}, 32'h1);
        apb(1'b1, `RCW_OFF_PAD, 32'h000a);
        period(0, cyc);
        chk(cyc, 8);
        apb(1'b1, `RCW_OFF_PAD, 32'h8002);
        period(0, cyc);
        chk(cyc, 0);
        done("ref_divider");

        en_p <= 1'b0;
        en_n <= 1'b1;
        apb(1'b1, `RCW_OFF_PAD, 32'h800c);
        period(0, cyc);
        chk(cyc, 8);
        apb(1'b1, `RCW_OFF_PAD, 32'h800a);
        period(0, cyc);
        chk(cyc, 0);
        apb(1'b1, `RCW_OFF_PAD, 32'h800e);
        period(3, cyc);
        chk(cyc, 8);
        done("modes");

        en_p <= 1'b1;
        en_n <= 1'b0;
        apb(1'b1, `RCW_OFF_PAD, 32'h800a);
        rl = '{0, 1, 2, 5};
        foreach (rl[i]) begin
            // monitor held in soft reset while its window is reprogrammed
            apb(1'b1, `RCW_OFF_CTRL, 32'h1);
            apb(1'b1, `RCW_OFF_WIN, rl[i]);
            apb(1'b1, `RCW_OFF_CTRL, 32'h0);
            period(1, cyc);
            chk(cyc, (rl[i] < 2) ? 8 : 8 * rl[i]);
            period(2, cyc);
            chk(cyc, (rl[i] < 2) ? 8 : 8 * rl[i]);
            rd_chk(`RCW_OFF_STS, ((rl[i] < 2) ? 8 : 8 * rl[i]) << 16, 32'hffff0000);
        end
        apb(1'b1, `RCW_OFF_CTRL, 32'h1);
        chk({31'h0, monitor0_soft_reset}, 32'h1);
        period(1, cyc);
        chk(cyc, 0);
        done("monitor_window");
        print_verdict();
    end
endmodule // rcw_refclk_los_cfg_bench
`default_nettype wire
